// file: logic/mrd_run_ctrl.sv
// Run-control and fault register bank of a sensorless motor controller
`default_nettype none
// Function
// - The diagnostic pin shows the inverted general fault, the inverted sync-lost flag, the drain-source compare or a half-rate clock per the 2-bit select.
// - With restart enabled a loss of sync restarts the start-up sequence, otherwise the motor stays stopped.
// - With run and brake set the bridge brakes by turning on all low sides.
// - Rotation sense 0 steps commutation states 1 to 6, sense 1 steps 6 to 1.
// - With run clear all bridge outputs are off, with run set the motor runs.
// - Mask bits 11 to 0 are overheat, shutdown, sync loss, bootcaps A-C and the six drain-source faults.
// - A mask bit of 0 permits detection of its fault and 1 disables it.
// - Status bit 15 is general fault, 14 power-up, 13 undervoltage, 11 to 0 as the mask.
// - A fault flag reads 1 once its fault is detected and 0 otherwise.
// - Overheat warning and thermal shutdown are separate flags in bits 11 and 10.
// - After reset general and power-up flags read 1, other status bits 0, mask bits 0.
// - The run-control word is addressed by bits 15 to 13 equal 111 with the write flag in bit 12.
module mrd_run_ctrl (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Host word port
  input wire logic word_valid_i,
  input wire logic [15:0] word_i,
  output logic [15:0] status_o,
  // Fault detector pins
  input wire logic [11:0] fault_raw_i,
  input wire logic undervoltage_i,
  input wire logic drain_source_compare_i,
  // Back-EMF commutation strobe
  input wire logic commutate_i,
  // Bridge and diagnostic outputs
  output logic [5:0] gate_o,
  output logic restart_o,
  output logic fault_indicator_pin_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] run_word;
  logic [11:0] fault_mask_word;
  logic [11:0] flt_s1;
  logic [11:0] flt_s2;
  logic [1:0] uv_sync;
  logic [1:0] vds_sync;
  logic los_prev;
  logic los_evt;
  logic stalled;
  logic clk_div;
  logic word_wr;
  logic [2:0] word_addr;
  logic run_en;
  logic [1:0] fault_indicator_pin_output_select;
  logic rev;
  mrd_pkg::mrd_comm_t comm_state;
  mrd_pkg::mrd_comm_t next_comm;
  mrd_fault_if flt ();

  mrd_fault_latch u_latch (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .flt(flt.latch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Word decode
  assign word_addr = word_i[mrd_pkg::ADDR_HI:mrd_pkg::ADDR_LO];
  assign word_wr = word_valid_i && word_i[mrd_pkg::WR_BIT];
  assign run_en = run_word[mrd_pkg::RUN_BIT];
  assign fault_indicator_pin_output_select = run_word[mrd_pkg::DG_HI:mrd_pkg::DG_LO];
  assign rev = run_word[mrd_pkg::DIR_BIT];

  // Run-control word
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_word <= mrd_pkg::RUN_RESET;
    end else if (ce_i && word_wr && word_addr == mrd_pkg::ADDR_RUN) begin
      run_word <= word_i[mrd_pkg::FLD_W-1:0];
    end
  end

  // Fault mask word
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_mask_word <= mrd_pkg::MASK_RESET;
    end else if (ce_i && word_wr && word_addr == mrd_pkg::ADDR_MASK) begin
      fault_mask_word <= word_i[mrd_pkg::FLD_W-1:0];
    end
  end

  // Every word returns the status word and clears read flags
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_o <= mrd_pkg::STATUS_RESET;
    end else if (ce_i && word_valid_i) begin
      status_o <= flt.status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flt_s1 <= 12'h000;
      flt_s2 <= 12'h000;
      uv_sync <= 2'h0;
      vds_sync <= 2'h0;
    end else if (ce_i) begin
      flt_s1 <= fault_raw_i;
      flt_s2 <= flt_s1;
      uv_sync <= {uv_sync[0], undervoltage_i};
      vds_sync <= {vds_sync[0], drain_source_compare_i};
    end
  end

  // Fault latch hookup
  assign flt.ce = ce_i;
  assign flt.clr = word_valid_i;
  assign flt.uv_raw = uv_sync[1];
  assign flt.raw = flt_s2;
  assign flt.mask = fault_mask_word;

  ////////////////////////////////////////////////////////////////////////////
  // Unmasked loss-of-sync edge
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      los_prev <= 1'b0;
    end else if (ce_i) begin
      los_prev <= flt_s2[mrd_pkg::ST_LOS];
    end
  end
  assign los_evt = flt_s2[mrd_pkg::ST_LOS] && !los_prev &&
                   !fault_mask_word[mrd_pkg::ST_LOS];

  // Without restart a sync loss stops the motor until run is cleared
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stalled <= 1'b0;
    end else if (ce_i) begin
      if (!run_en) begin
        stalled <= 1'b0;
      end else if (los_evt && !run_word[mrd_pkg::RSC_BIT]) begin
        stalled <= 1'b1;
      end
    end
  end

  // Restart pulse
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      restart_o <= 1'b0;
    end else if (ce_i) begin
      restart_o <= los_evt && run_en && !stalled &&
                   run_word[mrd_pkg::RSC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commutation step in either direction
  always_comb begin
    next_comm = comm_state;
    if (commutate_i) begin
      case (comm_state)
        mrd_pkg::MRD_S1: next_comm = rev ? mrd_pkg::MRD_S6 : mrd_pkg::MRD_S2;
        mrd_pkg::MRD_S2: next_comm = rev ? mrd_pkg::MRD_S1 : mrd_pkg::MRD_S3;
        mrd_pkg::MRD_S3: next_comm = rev ? mrd_pkg::MRD_S2 : mrd_pkg::MRD_S4;
        mrd_pkg::MRD_S4: next_comm = rev ? mrd_pkg::MRD_S3 : mrd_pkg::MRD_S5;
        mrd_pkg::MRD_S5: next_comm = rev ? mrd_pkg::MRD_S4 : mrd_pkg::MRD_S6;
        mrd_pkg::MRD_S6: next_comm = rev ? mrd_pkg::MRD_S5 : mrd_pkg::MRD_S1;
        default: next_comm = mrd_pkg::MRD_S1;
      endcase
    end
  end

  // Commutation state; idle, stall and restart return to state 1
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      comm_state <= mrd_pkg::MRD_S1;
    end else if (ce_i) begin
      if (!run_en || stalled || los_evt) begin
        comm_state <= mrd_pkg::MRD_S1;
      end else begin
        comm_state <= next_comm;
      end
    end
  end

  // Bridge drive: off, brake, stalled, or commutation pattern
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gate_o <= mrd_pkg::GATE_OFF;
    end else if (ce_i) begin
      if (!run_en) begin
        gate_o <= mrd_pkg::GATE_OFF;
      end else if (run_word[mrd_pkg::BRK_BIT]) begin
        gate_o <= mrd_pkg::GATE_BRAKE;
      end else if (stalled) begin
        gate_o <= mrd_pkg::GATE_OFF;
      end else begin
        case (comm_state)
          mrd_pkg::MRD_S1: gate_o <= mrd_pkg::GATE_S1;
          mrd_pkg::MRD_S2: gate_o <= mrd_pkg::GATE_S2;
          mrd_pkg::MRD_S3: gate_o <= mrd_pkg::GATE_S3;
          mrd_pkg::MRD_S4: gate_o <= mrd_pkg::GATE_S4;
          mrd_pkg::MRD_S5: gate_o <= mrd_pkg::GATE_S5;
          mrd_pkg::MRD_S6: gate_o <= mrd_pkg::GATE_S6;
          default: gate_o <= mrd_pkg::GATE_OFF;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-rate clock for the diagnostic pin
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_div <= 1'b0;
    end else if (ce_i) begin
      clk_div <= !clk_div;
    end
  end

  // Diagnostic pin select
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_indicator_pin_o <= 1'b0;
    end else if (ce_i) begin
      case (fault_indicator_pin_output_select)
        mrd_pkg::DG_FAULT:
          fault_indicator_pin_o <= !flt.status[mrd_pkg::ST_GEN];
        mrd_pkg::DG_LOS:
          fault_indicator_pin_o <= !flt.status[mrd_pkg::ST_LOS];
        mrd_pkg::DG_VDS: fault_indicator_pin_o <= vds_sync[1];
        mrd_pkg::DG_CLK: fault_indicator_pin_o <= clk_div;
        default: fault_indicator_pin_o <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_fault_indicator_pin_fault_sel: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_i && fault_indicator_pin_output_select == mrd_pkg::DG_FAULT) |=>
    (fault_indicator_pin_o == !$past(flt.status[mrd_pkg::ST_GEN])))
    else $error("Diagnostic pin not showing fault");

  a_fault_indicator_pin_los_sel: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_i && fault_indicator_pin_output_select == mrd_pkg::DG_LOS) |=>
    (fault_indicator_pin_o == !$past(flt.status[mrd_pkg::ST_LOS])))
    else $error("Diagnostic pin not showing sync loss");

  a_run_off_coast: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_i && !run_en) |=> (gate_o == mrd_pkg::GATE_OFF))
    else $error("Bridge driven while run clear");

  a_brake_low_sides: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_i && run_en && run_word[mrd_pkg::BRK_BIT]) |=>
    (gate_o == mrd_pkg::GATE_BRAKE))
    else $error("Brake pattern missing");

  a_dir_forward: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_i && run_en && !stalled && !los_evt && commutate_i &&
     !run_word[mrd_pkg::DIR_BIT] && comm_state == mrd_pkg::MRD_S6) |=>
    (comm_state == mrd_pkg::MRD_S1))
    else $error("Forward step wrong");

  a_dir_reverse: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_i && run_en && !stalled && !los_evt && commutate_i &&
     run_word[mrd_pkg::DIR_BIT] && comm_state == mrd_pkg::MRD_S1) |=>
    (comm_state == mrd_pkg::MRD_S6))
    else $error("Reverse step wrong");

  a_restart_pulse: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_i && los_evt && run_en && !stalled && run_word[mrd_pkg::RSC_BIT])
    |=> (restart_o && comm_state == mrd_pkg::MRD_S1))
    else $error("Restart after sync loss missing");

  a_no_restart_stop: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_i && los_evt && run_en && !run_word[mrd_pkg::RSC_BIT] &&
     !run_word[mrd_pkg::BRK_BIT]) |=> (!restart_o && stalled) ##1
    (gate_o == mrd_pkg::GATE_OFF || !ce_i))
    else $error("Motor not stopped on sync loss");
endmodule : mrd_run_ctrl
`default_nettype wire

// file: inc/mrd_pkg.sv
// Constants and types for the motor run-control and fault register bank
`default_nettype none
package mrd_pkg;
  // Serial word layout: address, write flag
  localparam int unsigned ADDR_HI = 15;
  localparam int unsigned ADDR_LO = 13;
  localparam int unsigned WR_BIT = 12;
  localparam logic [2:0] ADDR_RUN = 3'h7;
  localparam logic [2:0] ADDR_MASK = 3'h6;
  localparam int unsigned FLD_W = 12;

  // Run-control word fields and power-on values of the run-control and mask words
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned DIR_BIT = 1;
  localparam int unsigned BRK_BIT = 2;
  localparam int unsigned RSC_BIT = 3;
  localparam int unsigned DG_LO = 4;
  localparam int unsigned DG_HI = 5;
  localparam logic [11:0] RUN_RESET = 12'h200;
  localparam logic [11:0] MASK_RESET = 12'h000;

  // Fault status word positions and power-on value
  localparam int unsigned ST_GEN = 15;
  localparam int unsigned ST_POR = 14;
  localparam int unsigned ST_UV = 13;
  localparam int unsigned ST_SPARE = 12;
  localparam int unsigned ST_TW = 11;
  localparam int unsigned ST_TS = 10;
  localparam int unsigned ST_LOS = 9;
  localparam logic [15:0] STATUS_RESET = 16'hc000;

  // Diagnostic pin selections
  localparam logic [1:0] DG_FAULT = 2'h0;
  localparam logic [1:0] DG_LOS = 2'h1;
  localparam logic [1:0] DG_VDS = 2'h2;
  localparam logic [1:0] DG_CLK = 2'h3;

  // Commutation states, one-hot
  typedef enum logic [5:0] {
    MRD_S1 = 6'h01,
    MRD_S2 = 6'h02,
    MRD_S3 = 6'h04,
    MRD_S4 = 6'h08,
    MRD_S5 = 6'h10,
    MRD_S6 = 6'h20
  } mrd_comm_t;

  // Gate patterns, bit order {ah, al, bh, bl, ch, cl}
  localparam logic [5:0] GATE_S1 = 6'h24;
  localparam logic [5:0] GATE_S2 = 6'h21;
  localparam logic [5:0] GATE_S3 = 6'h09;
  localparam logic [5:0] GATE_S4 = 6'h18;
  localparam logic [5:0] GATE_S5 = 6'h12;
  localparam logic [5:0] GATE_S6 = 6'h06;
  localparam logic [5:0] GATE_BRAKE = 6'h15;
  localparam logic [5:0] GATE_OFF = 6'h00;
endpackage : mrd_pkg
`default_nettype wire

// file: inc/mrd_fault_if.sv
// Carrier between run-control logic and the fault latch
`default_nettype none
interface mrd_fault_if;
  logic ce;
  logic clr;
  logic uv_raw;
  logic [11:0] raw;
  logic [11:0] mask;
  logic [15:0] status;
  modport latch (input ce, clr, uv_raw, raw, mask, output status);
  modport ctrl (output ce, clr, uv_raw, raw, mask, input status);
endinterface : mrd_fault_if
`default_nettype wire

// file: logic/mrd_fault_latch.sv
// Sticky fault status word with per-fault masking
`default_nettype none
module mrd_fault_latch (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Fault carrier
  mrd_fault_if.latch flt
);
  logic [11:0] set_vec;
  logic [15:0] next_status;

  // Masked faults never reach a flag; set wins over read clear
  always_comb begin
    set_vec = flt.raw & ~flt.mask;
    next_status = flt.status & ~{16{flt.clr}};
    next_status[11:0] = next_status[11:0] | set_vec;
    next_status[mrd_pkg::ST_UV] = next_status[mrd_pkg::ST_UV] | flt.uv_raw;
    next_status[mrd_pkg::ST_GEN] = next_status[mrd_pkg::ST_GEN] |
                                   (|set_vec) | flt.uv_raw;
    next_status[mrd_pkg::ST_SPARE] = 1'b0;
  end

  // Status register, power-on value has general and power-up set
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flt.status <= mrd_pkg::STATUS_RESET;
    end else if (flt.ce) begin
      flt.status <= next_status;
    end
  end

  a_mask_blocks: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (flt.ce && flt.clr) |=> ((flt.status[11:0] & $past(flt.mask)) == 12'h000))
    else $error("Masked fault reached status");

  a_fault_sets: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (flt.ce && (set_vec != 12'h000)) |=>
    ((flt.status[11:0] & $past(set_vec)) == $past(set_vec)))
    else $error("Detected fault not flagged");

  a_general_follows: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (flt.ce && (set_vec != 12'h000)) |=> flt.status[mrd_pkg::ST_GEN])
    else $error("General fault flag missed");
endmodule : mrd_fault_latch
`default_nettype wire

// file: dv/mrd_host.sv
// Host-side word driver for the run-control register bank
`default_nettype none
module mrd_host (
  // Clock
  input wire logic clk_i,
  // Word port
  input wire logic [15:0] status_i,
  output logic word_valid_o,
  output logic [15:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port at time zero
  initial begin
    word_valid_o = 1'b0;
    word_o = 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // One word a transfer, launched just after an edge and taken at the next;
  // the word lines then show the inverse so stale data is never read back
  task automatic xfer(input logic [15:0] w, output logic [15:0] st);
    @(posedge clk_i);
    word_valid_o <= 1'b1;
    word_o <= w;
    @(posedge clk_i);
    word_valid_o <= 1'b0;
    word_o <= ~w;
    #1;
    st = status_i;
  endtask : xfer
endmodule : mrd_host
`default_nettype wire

// file: dv/mrd_run_ctrl_test.sv
// Self-checking bench for the run-control and fault register bank
`default_nettype none
module mrd_run_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  // Gate patterns expected after each commutation pulse
  localparam logic [5:0] FWD [6] = '{mrd_pkg::GATE_S2, mrd_pkg::GATE_S3,
    mrd_pkg::GATE_S4, mrd_pkg::GATE_S5, mrd_pkg::GATE_S6, mrd_pkg::GATE_S1};
  localparam logic [5:0] REV [6] = '{mrd_pkg::GATE_S6, mrd_pkg::GATE_S5,
    mrd_pkg::GATE_S4, mrd_pkg::GATE_S3, mrd_pkg::GATE_S2, mrd_pkg::GATE_S1};

  logic clk;
  logic nrst;
  logic wv;
  logic [15:0] w;
  logic [15:0] st;
  logic [11:0] raw;
  logic uv;
  logic dsc;
  logic com;
  logic [5:0] gate;
  logic rst_o;
  logic pin;
  logic [15:0] s;
  logic seen;
  logic a;
  logic ce;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  mrd_run_ctrl dut_u (.sys_clk_i(clk), .nrst_i(nrst), .ce_i(ce),
    .word_valid_i(wv), .word_i(w), .status_o(st), .fault_raw_i(raw),
    .undervoltage_i(uv), .drain_source_compare_i(dsc), .commutate_i(com),
    .gate_o(gate), .restart_o(rst_o), .fault_indicator_pin_o(pin));

  mrd_host host_u (.clk_i(clk), .status_i(st), .word_valid_o(wv),
    .word_o(w));

  //////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Compare, transfer and verdict tasks
  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_gate(input string nm, input logic [5:0] e);
    cmp_count++;
    if (gate !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, gate);
    end
  endtask : chk_gate

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic rd(input logic [15:0] e);
    host_u.xfer(16'h0000, s);
    chk_word("status word", e, s);
  endtask : rd

  task automatic wr(input logic [15:0] v);
    host_u.xfer(v, s);
  endtask : wr

  // One commutation pulse, gate checked after its one-cycle lag
  task automatic step(input logic [5:0] e);
    @(posedge clk);
    com <= 1'b1;
    @(posedge clk);
    com <= 1'b0;
    tick(1);
    #1;
    chk_gate("gate pattern", e);
  endtask : step

  // Watch a few cycles for a restart pulse
  task automatic watch_restart();
    seen = 1'b0;
    repeat (8) begin
      tick(1);
      #1;
      if (rst_o === 1'b1) seen = 1'b1;
    end
  endtask : watch_restart

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    raw = 12'h000;
    uv = 1'b0;
    dsc = 1'b0;
    com = 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    #1;
    chk_bit("fault_indicator_pin after reset", 1'b0, pin);
    rd(16'hc000);
    rd(16'h0000);
    // Each fault bit lands in its own place and stays until read
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      raw <= 12'h001 << i;
      tick(4);
      raw <= 12'h000;
      tick(3);
      rd(16'h8000 | (16'h0001 << i));
      rd(16'h0000);
    end
    // Masked faults stay silent
    wr(16'hdfff);
    @(posedge clk);
    raw <= 12'hfff;
    tick(5);
    #1;
    chk_bit("fault_indicator_pin masked", 1'b1, pin);
    rd(16'h0000);
    @(posedge clk);
    raw <= 12'h000;
    tick(3);
    wr(16'hd000);
    rd(16'h0000);
    // Undervoltage is reported and drives the general fault
    @(posedge clk);
    uv <= 1'b1;
    tick(4);
    #1;
    chk_bit("fault_indicator_pin undervoltage", 1'b0, pin);
    @(posedge clk);
    uv <= 1'b0;
    tick(3);
    rd(16'ha000);
    // Run, both directions, brake, coast
    wr(16'hf001);
    tick(1);
    #1;
    chk_gate("gate run", mrd_pkg::GATE_S1);
    for (int k = 0; k < 6; k++) step(FWD[k]);
    wr(16'hf003);
    for (int k = 0; k < 6; k++) step(REV[k]);
    wr(16'hf005);
    tick(1);
    #1;
    chk_gate("gate brake", mrd_pkg::GATE_BRAKE);
    wr(16'hf000);
    tick(1);
    #1;
    chk_gate("gate coast", mrd_pkg::GATE_OFF);
    // Sync loss with and without restart
    wr(16'hf009);
    step(mrd_pkg::GATE_S2);
    @(posedge clk);
    raw <= 12'h200;
    watch_restart();
    chk_bit("restart pulse", 1'b1, seen);
    chk_gate("gate restart", mrd_pkg::GATE_S1);
    @(posedge clk);
    raw <= 12'h000;
    tick(3);
    wr(16'hf001);
    @(posedge clk);
    raw <= 12'h200;
    watch_restart();
    chk_bit("no restart", 1'b0, seen);
    chk_gate("gate stalled", mrd_pkg::GATE_OFF);
    @(posedge clk);
    raw <= 12'h000;
    tick(3);
    // Diagnostic pin selections
    wr(16'hf010);
    tick(2);
    #1;
    chk_bit("fault_indicator_pin sync clear", 1'b1, pin);
    @(posedge clk);
    raw <= 12'h200;
    tick(5);
    #1;
    chk_bit("fault_indicator_pin sync lost", 1'b0, pin);
    @(posedge clk);
    raw <= 12'h000;
    wr(16'hf020);
    @(posedge clk);
    dsc <= 1'b1;
    tick(4);
    #1;
    chk_bit("fault_indicator_pin compare high", 1'b1, pin);
    @(posedge clk);
    dsc <= 1'b0;
    tick(4);
    #1;
    chk_bit("fault_indicator_pin compare low", 1'b0, pin);
    wr(16'hf030);
    tick(2);
    #1;
    a = pin;
    tick(1);
    #1;
    chk_bit("fault_indicator_pin clock", ~a, pin);
    // Clock enable low freezes the pin and ignores host words
    @(posedge clk);
    ce <= 1'b0;
    tick(1);
    #1;
    a = pin;
    wr(16'hf001);
    tick(1);
    #1;
    chk_bit("fault_indicator_pin frozen", a, pin);
    chk_gate("gate frozen", mrd_pkg::GATE_OFF);
    test_done();
  end
endmodule : mrd_run_ctrl_test
`default_nettype wire
